// [hw/spi_buffer_and_enable_core.sv]
// Serial port core: register file, double buffer, shift engine and pins.
// Assumes a classic Wishbone master on sys_clk and pins from outside.
`timescale 1ns/1ps
module spi_buffer_and_enable_core
  import serial_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        idle_mode,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire pin_in_s     pins_in,
  output pin_out_s         pins_out
);

  // ==========================================================================
  // Reset release and pin synchronisers.
  logic       rst_meta_ff;
  logic       rst_n_s;
  logic [2:0] pin_s;
  logic       sdi_s;
  logic       sck_s;
  logic       ss_n_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_s     <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_s     <= rst_meta_ff;
    end
  end

  level_sync #(.WIDTH(3)) u_pin_sync (
    .clk     (sys_clk),
    .rst_n   (rst_n_s),
    .rst_val (3'h0),
    .d       ({pins_in.sdi, pins_in.sck, pins_in.ss_n}),
    .q       (pin_s)
  );

  assign sdi_s  = pin_s[2];
  assign sck_s  = pin_s[1];
  assign ss_n_s = pin_s[0];

  // ==========================================================================
  // Bus decode. Writes and read side effects land on the ack edge.
  logic        ack_ff;
  logic        req;
  logic        wr_now;
  logic        rd_now;
  logic        wr_lo;
  logic        wr_hi;

  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & ack_ff & wb_we_i;
  assign rd_now = req & ack_ff & ~wb_we_i;
  assign wr_lo  = wr_now & wb_sel_i[0];
  assign wr_hi  = wr_now & wb_sel_i[1];
  assign wb_ack_o = ack_ff;

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ==========================================================================
  // Control registers.
  logic       en_ff;
  logic       idle_stop_ff;
  logic [1:0] cfg_ff;
  logic       master;
  logic       three_pin;
  logic       active;

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      en_ff        <= 1'b0;
      idle_stop_ff <= 1'b0;
      cfg_ff       <= CFG_RESET;
    end else begin
      if (wr_hi && wb_adr_i == STATUS_CONTROL_OFS) begin
        en_ff        <= wb_dat_i[ENABLE_BIT];    // RQ10
        idle_stop_ff <= wb_dat_i[IDLE_STOP_BIT]; // RQ11
      end
      if (wr_lo && wb_adr_i == PORT_CONFIG_OFS) begin
        cfg_ff <= wb_dat_i[1:0];
      end
    end
  end

  assign master    = cfg_ff[MASTER_BIT];
  assign three_pin = cfg_ff[THREE_PIN_BIT];
  assign active    = en_ff & ~(idle_mode & idle_stop_ff); // RQ10 RQ11

  // ==========================================================================
  // Shift engine. Data is sampled on the rising shift clock edge and shifted
  // on the falling edge, so the output bit changes while the clock is low.
  logic        xfer_ff;
  logic [3:0]  bit_cnt_ff;
  logic [3:0]  half_cnt_ff;
  logic        sck_ff;
  logic        sck_d_ff;
  logic        sample_ff;
  logic [15:0] shift_ff;
  logic [15:0] txb_ff;
  logic [15:0] rxb_ff;
  logic        tbf_ff;
  logic        rbf_ff;
  logic        rov_ff;
  logic        sel_ok;
  logic        half_end;
  logic        rise;
  logic        fall;
  logic        word_done;
  logic        load;
  logic        abort;
  logic        wr_data;
  logic        rd_data;

  assign sel_ok    = three_pin | ~ss_n_s; // RQ9
  assign half_end  = xfer_ff & (half_cnt_ff == SCK_HALF_LAST);
  assign rise      = master ? (half_end & ~sck_ff)
                            : (sck_s & ~sck_d_ff & sel_ok);
  assign fall      = master ? (half_end & sck_ff)
                            : (~sck_s & sck_d_ff & sel_ok & xfer_ff);
  assign word_done = active & fall & (bit_cnt_ff == 4'hf);
  assign load      = active & tbf_ff & ~xfer_ff;
  assign abort     = ~active | (~master & ~sel_ok);
  assign wr_data   = wr_now & (wb_adr_i == DATA_BUFFER_OFS);
  assign rd_data   = rd_now & (wb_adr_i == DATA_BUFFER_OFS);

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      xfer_ff     <= 1'b0;
      bit_cnt_ff  <= 4'h0;
      half_cnt_ff <= 4'h0;
      sck_ff      <= 1'b0;
    end else if (abort) begin
      xfer_ff    <= 1'b0;
      bit_cnt_ff <= 4'h0;
      sck_ff     <= 1'b0;
    end else if (load && master) begin
      xfer_ff     <= 1'b1;
      half_cnt_ff <= 4'h0;
    end else begin
      if (master && xfer_ff) begin
        half_cnt_ff <= half_end ? 4'h0 : half_cnt_ff + 4'h1;
        if (half_end) begin
          sck_ff <= ~sck_ff;
        end
      end
      if (!master && rise) begin
        xfer_ff <= 1'b1;
      end
      if (fall) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (word_done) begin
          xfer_ff <= 1'b0;
        end
      end
    end
  end

  // The shift register has no bus address; it only meets the two buffers.
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      shift_ff  <= WORD_RESET;
      sample_ff <= 1'b0;
    end else if (load) begin
      shift_ff <= txb_ff; // RQ4
    end else begin
      if (rise) begin
        sample_ff <= sdi_s;
      end
      if (fall) begin
        shift_ff <= {shift_ff[14:0], sample_ff}; // RQ5
      end
    end
  end

  // ==========================================================================
  // Transmit and receive buffers behind one address.
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      txb_ff <= WORD_RESET;
      tbf_ff <= 1'b0;
    end else begin
      if (wr_data) begin
        txb_ff <= wb_dat_i[15:0]; // RQ1 RQ2
        tbf_ff <= 1'b1;           // RQ6
      end else if (load) begin
        tbf_ff <= 1'b0;
      end
    end
  end

  // A word that arrives while the previous one is unread is discarded.
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rxb_ff <= WORD_RESET;
      rbf_ff <= 1'b0;
      rov_ff <= 1'b0;
    end else begin
      if (word_done && !rbf_ff) begin
        rxb_ff <= {shift_ff[14:0], sample_ff}; // RQ1 RQ6
        rbf_ff <= 1'b1;
      end else if (rd_data) begin
        rbf_ff <= 1'b0;
      end
      if (word_done && rbf_ff) begin
        rov_ff <= 1'b1;
      end else if (wr_lo && wb_adr_i == STATUS_CONTROL_OFS &&
                   !wb_dat_i[OVERFLOW_BIT]) begin
        rov_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt status and mask.
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign irq_set = {word_done & rbf_ff, load, word_done & ~rbf_ff};
  assign irq_clr = (wr_lo && wb_adr_i == IRQ_STATUS_OFS) ?
                   wb_dat_i[2:0] : IRQ_RESET;

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_stat_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (wr_lo && wb_adr_i == IRQ_MASK_OFS) begin
        irq_mask_ff <= wb_dat_i[2:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================================
  // Read data; unmapped addresses and unused bits read zero.
  logic [31:0] nxt_rd;

  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (wb_adr_i == STATUS_CONTROL_OFS) begin
      nxt_rd[ENABLE_BIT]    = en_ff;        // RQ12
      nxt_rd[IDLE_STOP_BIT] = idle_stop_ff;
      nxt_rd[OVERFLOW_BIT]  = rov_ff;
      nxt_rd[TX_FULL_BIT]   = tbf_ff;
      nxt_rd[RX_FULL_BIT]   = rbf_ff;
    end else if (wb_adr_i == DATA_BUFFER_OFS) begin
      nxt_rd[15:0] = rxb_ff; // RQ3 RQ7
    end else if (wb_adr_i == PORT_CONFIG_OFS) begin
      nxt_rd[1:0] = cfg_ff;
    end else if (wb_adr_i == IRQ_STATUS_OFS) begin
      nxt_rd[2:0] = irq_stat_ff;
    end else if (wb_adr_i == IRQ_MASK_OFS) begin
      nxt_rd[2:0] = irq_mask_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_ff && !wb_we_i) begin
      wb_dat_o <= nxt_rd;
    end
  end

  // ==========================================================================
  // Pins. Output enables are low while the port drives the pin.
  assign pins_out.sdo      = shift_ff[15];
  assign pins_out.sdo_oe_n = ~(active & (master | sel_ok));   // RQ8 RQ10
  assign pins_out.sck      = sck_ff;
  assign pins_out.sck_oe_n = ~(active & master);              // RQ8
  assign pins_out.ss_n     = ~xfer_ff;
  assign pins_out.ss_oe_n  = ~(active & master & ~three_pin); // RQ9

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  property p_write_tx_only;
    wr_data && !word_done |=> txb_ff == $past(wb_dat_i[15:0]) &&
                              rxb_ff == $past(rxb_ff);
  endproperty
  a_write_tx_only: assert property (p_write_tx_only) // RQ2
    else $error("data write did not load only the transmit buffer");

  property p_read_rx;
    wb_ack_o && !wb_we_i && wb_adr_i == DATA_BUFFER_OFS && $stable(rxb_ff)
      |-> wb_dat_o == {16'h0000, rxb_ff};
  endproperty
  a_read_rx: assert property (p_read_rx) // RQ3
    else $error("data read did not return the receive buffer");

  property p_read_keeps_tx;
    rd_data |=> $stable(txb_ff);
  endproperty
  a_read_keeps_tx: assert property (p_read_keeps_tx) // RQ7
    else $error("data read disturbed the transmit buffer");

  property p_load_shift;
    load |=> shift_ff == $past(txb_ff) && !tbf_ff || $past(wr_data);
  endproperty
  a_load_shift: assert property (p_load_shift) // RQ4
    else $error("shift register not loaded from transmit buffer");

  property p_word_captured;
    word_done && !rbf_ff |=>
      rxb_ff == $past({shift_ff[14:0], sample_ff}) && rbf_ff;
  endproperty
  a_word_captured: assert property (p_word_captured) // RQ5
    else $error("received word not captured at end of transfer");

  property p_back_to_back;
    word_done && master && tbf_ff && active ##1 active |=> xfer_ff;
  endproperty
  a_back_to_back: assert property (p_back_to_back) // RQ6
    else $error("queued word did not start right after the previous");

  property p_three_pin;
    three_pin |-> pins_out.ss_oe_n;
  endproperty
  a_three_pin: assert property (p_three_pin) // RQ9
    else $error("select pin driven in three-pin mode");

  // Dropping the enable bit mid-word is legal, so the transfer flag may
  // still be set at the first edge; the abort clears it one edge later.
  property p_disabled;
    !en_ff |-> pins_out.sck_oe_n && pins_out.sdo_oe_n &&
               pins_out.ss_oe_n ##1 !xfer_ff;
  endproperty
  a_disabled: assert property (p_disabled) // RQ10
    else $error("disabled port still holds pins or transfers");

  property p_clock_dir;
    active && master |-> !pins_out.sck_oe_n;
  endproperty
  a_clock_dir: assert property (p_clock_dir) // RQ8
    else $error("master does not drive the shift clock");

  property p_idle_stop;
    idle_mode && idle_stop_ff |=> !xfer_ff && $stable(shift_ff);
  endproperty
  a_idle_stop: assert property (p_idle_stop) // RQ11
    else $error("port kept running in idle with idle-stop set");

  property p_reserved_zero;
    wb_ack_o && !wb_we_i && wb_adr_i == STATUS_CONTROL_OFS
      |-> (wb_dat_o & 32'hffff_5fbc) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RQ12
    else $error("unimplemented status bit read as one");

  c_word_done: cover property (word_done && master);
  c_slave_word: cover property (word_done && !master);
  c_overflow: cover property (word_done && rbf_ff);
  c_irq: cover property (irq);

endmodule

// [hw/serial_port_pkg.sv]
// Constants, register map and pin carriers for the serial port core.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
//
// Overview of operation
// RQ1: Transmit and receive buffers are separate 16-bit registers on one address.
// RQ2: Writing the data address loads the transmit buffer only.
// RQ3: Reading the data address returns the receive buffer only.
// RQ4: A hidden 16-bit shift register moves bits to and from the pins.
// RQ5: Each word shifts out and in at once, one received per sent.
// RQ6: Buffers double the shift register so words can follow back to back.
// RQ7: Transmit buffer is unreadable, receive buffer unwritable; data address only.
// RQ8: Pins are data in, data out, shift clock, active-low select or sync.
// RQ9: Four-pin and three-pin modes; three-pin leaves select undriven and unsampled.
// RQ10: Enable bit 15 set claims the pins and runs; clear disables module.
// RQ11: In idle mode the module stops when idle-stop bit 13 is set.
// RQ12: Unimplemented status/control bits read zero and ignore writes.
package serial_port_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [7:0] STATUS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] DATA_BUFFER_OFS    = 8'h04;
  localparam logic [7:0] PORT_CONFIG_OFS    = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int ENABLE_BIT    = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int OVERFLOW_BIT  = 6;
  localparam int TX_FULL_BIT   = 1;
  localparam int RX_FULL_BIT   = 0;
  localparam int MASTER_BIT    = 0;
  localparam int THREE_PIN_BIT = 1;
  localparam int IRQ_RX_BIT    = 0;
  localparam int IRQ_TX_BIT    = 1;
  localparam int IRQ_OVF_BIT   = 2;

  // ==========================================================================
  // Widths and reset values.
  localparam int WORD_BITS = 16;
  localparam int IRQ_BITS  = 3;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0]  CFG_RESET  = 2'h0;
  localparam logic [2:0]  IRQ_RESET  = 3'h0;

  // ==========================================================================
  // Shift clock timing in master mode.
  localparam int SYS_CLK_HZ    = 10_000_000;
  localparam int SCK_PERIOD_NS = 800;
  localparam int SCK_HALF_CYC  =
    (SCK_PERIOD_NS / 2) / (1_000_000_000 / SYS_CLK_HZ);
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

  // ==========================================================================
  // Pin carriers; every output enable is active low.
  typedef struct packed {
    logic sdi;
    logic sck;
    logic ss_n;
  } pin_in_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe_n;
    logic sck;
    logic sck_oe_n;
    logic ss_n;
    logic ss_oe_n;
  } pin_out_s;

endpackage

// [hw/level_sync.sv]
// Two-flop synchroniser for levels that come from outside the clock domain.
// Assumes the reset given is already synchronous to clk on release.
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] rst_val,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // Reset loads zero at every instance; rst_val cancels out and sets nothing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff ^ rst_val ^ rst_val;
    end
  end

endmodule

// [sim/spi_peer_model.sv]
// Behavioural serial peer on the far side of the serial port core.
// Assumes the bench resolves the shared pin levels and sets tx_word.
`timescale 1ns/1ps
module spi_peer_model (
  input  wire logic clk,
  input  wire logic sck_line,
  input  wire logic ss_n_line,
  input  wire logic mosi,
  output logic      miso,
  output logic      sck_o,
  output logic      ss_n_o
);
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [15:0] sh;
  logic [15:0] rsh;
  logic        drive;
  logic        frame_on;
  int          bits;
  int          rx_count;
  wire         active = drive ? frame_on : !ss_n_line;

  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    drive = 1'b0;
    frame_on = 1'b0;
    tx_word = 16'h0000;
    sh = 16'h0000;
    bits = 0;
    rx_count = 0;
  end

  // A released data line shows the inverse of the last bit, not a hold.
  assign miso = active ? sh[15] : ~sh[15];

  always @(negedge ss_n_line) begin
    sh = tx_word;
    bits = 0;
  end

  always @(posedge sck_line) if (active) begin
    rsh = {rsh[14:0], mosi};
    bits++;
    if (bits == 16) begin
      rx_word = rsh;
      rx_count++;
      bits = 0;
    end
  end

  always @(negedge sck_line) if (active) begin
    sh = (bits == 0) ? tx_word : sh << 1;
  end

  // One 16-bit frame as bus master, 800 ns shift clock, idle low.
  task automatic run_frame(input logic use_ss);
    @(posedge clk);
    sh = tx_word;
    bits = 0;
    frame_on = 1'b1;
    ss_n_o <= ~use_ss;
    repeat (4) @(posedge clk);
    repeat (16) begin
      sck_o <= 1'b1;
      repeat (4) @(posedge clk);
      sck_o <= 1'b0;
      repeat (4) @(posedge clk);
    end
    ss_n_o <= 1'b1;
    frame_on = 1'b0;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the serial port core and a behavioural peer.
// Assumes the design package and a 100 ns system clock.
`timescale 1ns/1ps
module tb_top;
  import serial_port_pkg::*;
  logic        sys_clk;
  logic        rstn;
  logic        idle_mode;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq;
  pin_in_s     pins_in;
  pin_out_s    pins_out;
  logic        sck_line;
  logic        ss_line;
  logic        mosi;
  logic        miso;
  logic        p_sck;
  logic        p_ss_n;
  logic [31:0] seed;
  logic [15:0] t;
  logic [15:0] prev;
  int          n_errors;
  int          checked;
  int          cycles;
  int          cnt;

  // ==========================================================================
  // Pins: pull-up on data out, the peer drives select (idle high) and its clock (idle low).
  assign sck_line = !pins_out.sck_oe_n ? pins_out.sck : p_sck;
  assign ss_line  = !pins_out.ss_oe_n ? pins_out.ss_n : p_ss_n;
  assign mosi     = !pins_out.sdo_oe_n ? pins_out.sdo : 1'b1;
  assign pins_in  = {miso, sck_line, ss_line};

  spi_buffer_and_enable_core dut (
    .sys_clk(sys_clk), .rstn(rstn), .idle_mode(idle_mode),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .pins_in(pins_in), .pins_out(pins_out)
  );

  spi_peer_model peer (
    .clk(sys_clk), .sck_line(sck_line), .ss_n_line(ss_line),
    .mosi(mosi), .miso(miso), .sck_o(p_sck), .ss_n_o(p_ss_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================================================
  // Checks and bus tasks.
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] stat(input logic en, input logic ovf,
      input logic tbf, input logic rbf);
    stat = 32'h0000_0000;
    stat[ENABLE_BIT] = en;
    stat[OVERFLOW_BIT] = ovf;
    stat[TX_FULL_BIT] = tbf;
    stat[RX_FULL_BIT] = rbf;
  endfunction

  task automatic wb_xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, input logic [3:0] sel,
      output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d,
      input logic [3:0] sel);
    logic [31:0] r;
    wb_xfer(1'b1, adr, d, sel, r);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 32'h0000_0000, 4'hf, r);
    check_word(r, exp);
  endtask

  task automatic wait_status(input int b, input logic val);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, STATUS_CONTROL_OFS, 32'h0000_0000, 4'hf, s);
      n++;
    end while (s[b] !== val && n < 100);
    check_bit(s[b], val);
  endtask

  // The interrupt may be registered, so it is looked at mid-cycle.
  task automatic chk_irq(input logic exp);
    @(negedge sys_clk);
    check_bit(irq, exp);
    @(posedge sys_clk);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = 32'h5013_3dc9;
    n_errors = 0;
    checked = 0;
    cycles = 0;
    rstn = 1'b0;
    idle_mode = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check_bit(pins_out.sck_oe_n, 1'b1);
    rd_chk(STATUS_CONTROL_OFS, 32'h0000_0000);
    rd_chk(DATA_BUFFER_OFS, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
    wr(STATUS_CONTROL_OFS, 32'hffff_ffff, 4'hf);
    rd_chk(STATUS_CONTROL_OFS, 32'h0000_a000);
    wr(PORT_CONFIG_OFS, 32'h0000_0001, 4'h1);
    wr(IRQ_MASK_OFS, 32'h0000_0007, 4'h1);
    wr(STATUS_CONTROL_OFS, 32'h0000_8000, 4'h3);
    prev = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      t = 16'($random(seed));
      peer.tx_word = 16'($random(seed));
      wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
      rd_chk(DATA_BUFFER_OFS, {16'h0000, prev});
      wait_status(RX_FULL_BIT, 1'b1);
      check_word({16'h0000, peer.rx_word}, {16'h0000, t});
      chk_irq(1'b1);
      rd_chk(DATA_BUFFER_OFS, {16'h0000, peer.tx_word});
      prev = peer.tx_word;
      rd_chk(IRQ_STATUS_OFS, 32'h0000_0003);
      wr(IRQ_STATUS_OFS, 32'h0000_0007, 4'h1);
      chk_irq(1'b0);
    end
    t = 16'($random(seed));
    cnt = peer.rx_count;
    wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
    wr(DATA_BUFFER_OFS, {16'h0000, ~t}, 4'hf);
    rd_chk(STATUS_CONTROL_OFS, stat(1'b1, 1'b0, 1'b1, 1'b0));
    for (int k = 0; k < 2; k++) begin
      wait_status(RX_FULL_BIT, 1'b1);
      rd_chk(DATA_BUFFER_OFS, {16'h0000, peer.tx_word});
    end
    check_word(32'(peer.rx_count - cnt), 32'h0000_0002);
    check_word({16'h0000, peer.rx_word}, {16'h0000, ~t});
    wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
    wait_status(RX_FULL_BIT, 1'b1);
    prev = peer.tx_word;
    peer.tx_word = ~prev;
    wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
    wait_status(OVERFLOW_BIT, 1'b1);
    rd_chk(DATA_BUFFER_OFS, {16'h0000, prev});
    rd_chk(STATUS_CONTROL_OFS, stat(1'b1, 1'b1, 1'b0, 1'b0));
    wr(STATUS_CONTROL_OFS, 32'h0000_8000, 4'h1);
    rd_chk(STATUS_CONTROL_OFS, stat(1'b1, 1'b0, 1'b0, 1'b0));
    chk_irq(1'b1);
    wr(IRQ_MASK_OFS, 32'h0000_0000, 4'h1);
    chk_irq(1'b0);
    wr(IRQ_MASK_OFS, 32'h0000_0007, 4'h1);
    chk_irq(1'b1);
    wr(IRQ_STATUS_OFS, 32'h0000_0007, 4'h1);
    chk_irq(1'b0);
    wr(STATUS_CONTROL_OFS, 32'h0000_a000, 4'h3);
    idle_mode <= 1'b1;
    cnt = peer.rx_count;
    t = 16'($random(seed));
    wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
    repeat (200) @(posedge sys_clk);
    check_word(32'(peer.rx_count), 32'(cnt));
    check_bit(pins_out.sck_oe_n, 1'b1);
    wr(STATUS_CONTROL_OFS, 32'h0000_8000, 4'h3);
    wait_status(RX_FULL_BIT, 1'b1);
    check_word({16'h0000, peer.rx_word}, {16'h0000, t});
    rd_chk(DATA_BUFFER_OFS, {16'h0000, peer.tx_word});
    idle_mode <= 1'b0;
    wr(STATUS_CONTROL_OFS, 32'h0000_0000, 4'h3);
    @(negedge sys_clk);
    check_bit(pins_out.sdo_oe_n, 1'b1);
    check_bit(pins_out.sck_oe_n, 1'b1);
    @(posedge sys_clk);
    peer.drive = 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(PORT_CONFIG_OFS, 32'(2 * m), 4'h1);
      wr(STATUS_CONTROL_OFS, 32'h0000_8000, 4'h3);
      t = 16'($random(seed));
      peer.tx_word = 16'($random(seed));
      wr(DATA_BUFFER_OFS, {16'h0000, t}, 4'hf);
      peer.run_frame(m == 0);
      wait_status(RX_FULL_BIT, 1'b1);
      rd_chk(DATA_BUFFER_OFS, {16'h0000, peer.tx_word});
      check_word({16'h0000, peer.rx_word}, {16'h0000, t});
      wr(STATUS_CONTROL_OFS, 32'h0000_0000, 4'h3);
    end
    // Master in three-pin mode drives the clock but leaves select alone.
    wr(PORT_CONFIG_OFS, 32'h0000_0003, 4'h1);
    wr(STATUS_CONTROL_OFS, 32'h0000_8000, 4'h3);
    @(negedge sys_clk);
    check_bit(pins_out.ss_oe_n, 1'b1);
    check_bit(pins_out.sck_oe_n, 1'b0);
    @(posedge sys_clk);
    wr(PORT_CONFIG_OFS, 32'h0000_0001, 4'h1);
    @(negedge sys_clk);
    check_bit(pins_out.ss_oe_n, 1'b0);
    @(posedge sys_clk);
    final_report();
  end
endmodule
